// >>> verilog/dms_mode_tone.sv
// mode decode, tuning-word select and phase accumulator of the synthesizer
// Operation
// (RULE_01) three-bit control field picks single tone, FSK, ramped FSK, chirp or BPSK
// (RULE_02) active-high init input returns port and registers to defaults
// (RULE_03) init leaves the device in single-tone mode
// (RULE_04) single tone uses the first 48-bit tuning word, reset value zero
// (RULE_05) after reset output is 0 Hz, zero phase, midscale amplitude
// (RULE_06) host computes tuning word as f times 2^48 over clock, rounded
// (RULE_07) frequency changes keep accumulator phase, continue with new increment
// (RULE_08) a 14-bit phase value offsets the cosine path
// (RULE_09) parameters may be rewritten anytime through the byte port
// (RULE_10) in FSK, keying low selects word one, high selects word two
// (RULE_11) word one at byte addresses 4..9, word two at A..F
// (RULE_12) FSK switching is phase continuous with fixed pipeline latency
// (RULE_13) keying input ignored in single tone; word one used in all modes other than FSK and ramped FSK
// (RULE_14) phase offset off in BPSK; word two only in FSK modes
// (RULE_15) accumulator adds increment each clock, wraps mod 2^48
// (RULE_16) codes 101 to 111 act as single tone
`include "dms_defines.svh"
module dms_mode_tone
	import dms_pkg::*;
#(
	parameter int ACC_W   = 48,
	parameter int PHASE_W = 14,
	parameter int OUT_W   = 14
) (
	input  wire logic               mclk,
	input  wire logic               rst_n,
	input  wire logic               clk_en,
	input  wire logic               master_reset,
	input  wire logic               wr_strobe,
	input  wire logic [7:0]         wr_addr,
	input  wire logic [7:0]         wr_data,
	input  wire logic               keying_select_input,
	output logic [2:0]              mode_out,
	output logic [ACC_W-1:0]        tuning_increment,
	output logic [OUT_W-1:0]        sine_phase,
	output logic [OUT_W-1:0]        cosine_phase,
	output logic                    using_second_word
);
	// widths the slicing below can serve
	if (ACC_W != 48 || PHASE_W != 14 || OUT_W > ACC_W || OUT_W < PHASE_W) begin : g_bad_width
		$error("dms_mode_tone: unsupported widths");
	end

	logic [ACC_W-1:0]   tw1_r, tw1_nxt;
	logic [ACC_W-1:0]   tw2_r, tw2_nxt;
	logic [PHASE_W-1:0] phase_r, phase_nxt;
	logic [7:0]         ctrl_r, ctrl_nxt;
	logic [`DMS_KEY_PIPE-1:0] key_r, key_nxt;
	logic [ACC_W-1:0]   acc_r, acc_nxt;
	logic [ACC_W-1:0]   inc_r, inc_nxt;
	logic [OUT_W-1:0]   sin_r, sin_nxt, cos_r, cos_nxt;
	logic               sel2_r, sel2_nxt;
	dms_mode_e          mode;
	logic               hit_tw1, hit_tw2, hit_ph_hi, hit_ph_lo, hit_ctrl;
	logic               key_late;
	logic [OUT_W-1:0]   acc_top;

	// raw control code to operating mode
	function automatic dms_mode_e decode_mode(input logic [2:0] code);
		unique case (code)
			3'h1:    decode_mode = DMS_FSK;
			3'h2:    decode_mode = DMS_RAMPED;
			3'h3:    decode_mode = DMS_CHIRP;
			3'h4:    decode_mode = DMS_BPSK;
			default: decode_mode = DMS_SINGLE; // RULE_16
		endcase
	endfunction : decode_mode

	// true when a byte address falls inside one tuning word
	function automatic logic in_word(input logic [7:0] a, input logic [7:0] first,
		input logic [7:0] last);
		in_word = (a >= first) && (a <= last);
	endfunction : in_word

	// word two only in the two frequency-keying modes
	function automatic logic word_two_mode(input dms_mode_e m);
		word_two_mode = (m == DMS_FSK) || (m == DMS_RAMPED);
	endfunction : word_two_mode

	// phase offset withheld in binary phase keying
	function automatic logic offset_mode(input dms_mode_e m);
		offset_mode = (m != DMS_BPSK);
	endfunction : offset_mode

	// replace one byte of a tuning word
	function automatic logic [ACC_W-1:0] put_byte(input logic [ACC_W-1:0] w,
		input logic [7:0] last, input logic [7:0] a, input logic [7:0] d);
		logic [ACC_W-1:0] r;
		int idx;
		r = w;
		idx = int'(last - a);
		r[idx*8 +: 8] = d;
		put_byte = r;
	endfunction : put_byte

	// mode seen by the datapath
	assign mode = decode_mode(ctrl_r[`DMS_MODE_LSB +: 3]); // RULE_01

	// byte-address decode of the write port
	assign hit_tw1   = in_word(wr_addr, `DMS_TW1_FIRST, `DMS_TW1_LAST); // RULE_11
	assign hit_tw2   = in_word(wr_addr, `DMS_TW2_FIRST, `DMS_TW2_LAST); // RULE_11
	assign hit_ph_hi = (wr_addr == `DMS_PHASE_HI);
	assign hit_ph_lo = (wr_addr == `DMS_PHASE_LO);
	assign hit_ctrl  = (wr_addr == `DMS_CTRL_ADDR);

	// oldest stage of the keying pipe
	assign key_late = key_r[`DMS_KEY_PIPE-1];
	// accumulator bits that feed the converters
	assign acc_top = acc_r[ACC_W-1 -: OUT_W];

	// register writes, most significant byte at the lowest address
	always_comb begin
		tw1_nxt = tw1_r;
		tw2_nxt = tw2_r;
		phase_nxt = phase_r;
		ctrl_nxt = ctrl_r;
		if (wr_strobe) begin // RULE_09
			if (hit_tw1)
				tw1_nxt = put_byte(tw1_r, `DMS_TW1_LAST, wr_addr, wr_data); // RULE_11
			else if (hit_tw2)
				tw2_nxt = put_byte(tw2_r, `DMS_TW2_LAST, wr_addr, wr_data); // RULE_11
			else if (hit_ph_hi)
				phase_nxt = {wr_data[PHASE_W-9:0], phase_r[7:0]};
			else if (hit_ph_lo)
				phase_nxt = {phase_r[PHASE_W-1:8], wr_data};
			else if (hit_ctrl)
				ctrl_nxt = wr_data;
		end
	end

	// keying pipeline and increment selection
	always_comb begin
		key_nxt = {key_r[`DMS_KEY_PIPE-2:0], keying_select_input}; // RULE_12
		sel2_nxt = 1'b0;
		if (word_two_mode(mode))
			sel2_nxt = key_late; // RULE_10 RULE_14
		else
			sel2_nxt = 1'b0; // RULE_13
		inc_nxt = sel2_nxt ? tw2_r : tw1_r; // RULE_04 RULE_10
	end

	// accumulator never cleared on a frequency change
	always_comb begin
		logic [OUT_W-1:0] off;
		off = '0;
		acc_nxt = acc_r + inc_r; // RULE_07 RULE_15
		if (offset_mode(mode))
			off = OUT_W'(phase_r) << (OUT_W - PHASE_W); // RULE_14
		sin_nxt = acc_top; // RULE_15
		cos_nxt = acc_top + off; // RULE_08
	end

	// programmed registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tw1_r   <= `DMS_TW_RESET;
			tw2_r   <= `DMS_TW_RESET;
			phase_r <= `DMS_PHASE_RESET;
			ctrl_r  <= `DMS_CTRL_RESET;
		end else if (clk_en) begin
			if (master_reset) begin // RULE_02 RULE_03
				tw1_r   <= `DMS_TW_RESET;
				tw2_r   <= `DMS_TW_RESET;
				phase_r <= `DMS_PHASE_RESET;
				ctrl_r  <= `DMS_CTRL_RESET;
			end else begin
				tw1_r   <= tw1_nxt;
				tw2_r   <= tw2_nxt;
				phase_r <= phase_nxt;
				ctrl_r  <= ctrl_nxt;
			end
		end
	end

	// keying pipe and selected increment
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			key_r  <= '0;
			inc_r  <= '0;
			sel2_r <= 1'b0;
		end else if (clk_en) begin
			if (master_reset) begin // RULE_02
				key_r  <= '0;
				inc_r  <= '0;
				sel2_r <= 1'b0;
			end else begin
				key_r  <= key_nxt;
				inc_r  <= inc_nxt;
				sel2_r <= sel2_nxt;
			end
		end
	end

	// accumulator and phase outputs
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			acc_r <= '0;
			sin_r <= '0;
			cos_r <= '0;
		end else if (clk_en) begin
			if (master_reset) begin // RULE_05
				acc_r <= '0;
				sin_r <= '0;
				cos_r <= '0;
			end else begin
				acc_r <= acc_nxt;
				sin_r <= sin_nxt;
				cos_r <= cos_nxt;
			end
		end
	end

	// outputs straight from registers

	assign mode_out          = ctrl_r[`DMS_MODE_LSB +: 3];
	assign tuning_increment  = inc_r;
	assign sine_phase        = sin_r;
	assign cosine_phase      = cos_r;
	assign using_second_word = sel2_r;
endmodule : dms_mode_tone

// >>> verilog/dms_defines.svh
// register offsets, field positions, reset values and timing for the mode/tone block
`ifndef DMS_DEFINES_SVH
`define DMS_DEFINES_SVH
`define DMS_TW1_FIRST     8'h04
`define DMS_TW1_LAST      8'h09
`define DMS_TW2_FIRST     8'h0A
`define DMS_TW2_LAST      8'h0F
`define DMS_PHASE_HI      8'h14
`define DMS_PHASE_LO      8'h15
`define DMS_CTRL_ADDR     8'h1F
`define DMS_MODE_LSB      0
`define DMS_TW_RESET      48'h000000000000
`define DMS_PHASE_RESET   14'h0000
`define DMS_CTRL_RESET    8'h00
`define DMS_KEY_PIPE      2
`endif

// >>> verilog/dms_pkg.sv
// types for the mode/tone block
package dms_pkg;
	typedef enum logic [2:0] {
		DMS_SINGLE  = 3'h0,
		DMS_FSK     = 3'h1,
		DMS_RAMPED  = 3'h2,
		DMS_CHIRP   = 3'h3,
		DMS_BPSK    = 3'h4
	} dms_mode_e;
endpackage : dms_pkg

// >>> verification/dms_mode_tone_checker.sv
// port assertions for the mode/tone block
module dms_mode_tone_checker #(parameter int ACC_W = 48, parameter int OUT_W = 14) (
	input wire logic             mclk,
	input wire logic             rst_n,
	input wire logic             master_reset,
	input wire logic             wr_strobe,
	input wire logic [7:0]       wr_addr,
	input wire logic [7:0]       wr_data,
	input wire logic             keying_select_input,
	input wire logic [2:0]       mode_out,
	input wire logic [ACC_W-1:0] tuning_increment,
	input wire logic [OUT_W-1:0] sine_phase,
	input wire logic [OUT_W-1:0] cosine_phase,
	input wire logic             using_second_word
);
	timeunit 1ns / 100ps;
	logic [2:0] run_r, run_nxt;
	logic       fsk;
	// cycles since the last init, saturating
	assign run_nxt = master_reset ? 3'h0 : run_r + 3'(run_r != 3'h7);
	assign fsk = mode_out inside {3'h1, 3'h2};
	always_ff @(posedge mclk or negedge rst_n) run_r <= !rst_n ? 3'h0 : run_nxt;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_init_clear: assert property (master_reset |=> !mode_out && !tuning_increment)
		else $error("init left outputs set");
	a_reset_idle: assert property ($rose(rst_n) |-> !tuning_increment && !cosine_phase)
		else $error("outputs not idle after reset");
	a_phase_step: assert property (run_r > 3'h3 |-> OUT_W'(sine_phase - $past(sine_phase)
		- $past(tuning_increment[ACC_W-1 -: OUT_W], 2)) <= 1) else $error("phase step wrong");
	a_key_word: assert property (fsk && $past(fsk, 4) && run_r > 3'h4
		|-> using_second_word == $past(keying_select_input, 3)) else $error("key select wrong");
	a_plain_word: assert property (!fsk && !$past(fsk, 3) && run_r > 3'h2
		|-> !using_second_word) else $error("word two used outside fsk");
	a_word_hold: assert property (mode_out == 3'h0 && !$past(wr_strobe, 2)
		&& run_r > 3'h2 |-> $stable(tuning_increment)) else $error("increment moved");
	a_low_byte: assert property ($past(wr_strobe, 2) && $past(wr_addr, 2) == 8'h09
		&& mode_out == 3'h0 && $past(mode_out) == 3'h0 && run_r > 3'h2
		|-> tuning_increment[7:0] == $past(wr_data, 2)) else $error("low byte wrong");
	a_cos_plain: assert property (mode_out == 3'h4 && $past(mode_out, 2) == 3'h4
		&& run_r > 3'h2 |-> cosine_phase == sine_phase) else $error("offset used in bpsk");
endmodule : dms_mode_tone_checker

// >>> verification/dms_host_model.sv
// host controller model: byte writes, keying and init
module dms_host_model (
	input wire logic mclk,
	output logic     master_reset,
	output logic     wr_strobe,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic     keying_select_input
);
	timeunit 1ns / 100ps;
	initial {master_reset, wr_strobe, wr_addr, wr_data, keying_select_input} = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk) #1;
		{wr_strobe, wr_addr, wr_data} = {1'b1, a, d};
		@(posedge mclk) #1;
		{wr_strobe, wr_data} = {1'b0, ~d};
	endtask : wr
	task automatic key(input logic v);
		@(posedge mclk) #1;
		keying_select_input = v;
		repeat (6) @(posedge mclk);
	endtask : key
	task automatic init();
		@(posedge mclk) #1;
		master_reset = 1;
		@(posedge mclk) #1;
		master_reset = 0;
	endtask : init
endmodule : dms_host_model

// >>> verification/tb_top.sv
// self-checking bench for the mode/tone block
module tb_top;
	timeunit 1ns / 100ps;
	`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
		$display("ERROR %0t got %h exp %h", $time, a, e); end end
	logic mclk = 0, rst_n = 0, clk_en = 1, master_reset, wr_strobe, keying_select_input;
	logic using_second_word;
	logic [7:0] wr_addr, wr_data;
	logic [2:0] mode_out;
	logic [47:0] tuning_increment, tw1, tw2;
	logic [13:0] sine_phase, cosine_phase, ph;
	logic [48:0] exp_q[$], last = '0, e;
	int mismatches = 0, tests_run = 0, cyc = 0;
	dms_host_model u_host(.*);
	dms_mode_tone u_dut(.*);
	always #2.5 mclk = ~mclk;
	always @(posedge mclk) if (++cyc == 3000) begin
		mismatches++;
		results();
	end
	always @(negedge mclk) if ({using_second_word, tuning_increment} !== last) begin
		last = {using_second_word, tuning_increment};
		e = exp_q.size() ? exp_q.pop_front() : ~last;
		`CHK(last, e)
	end
	task automatic results();
		$display("compares %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results
	initial begin
		void'($urandom(68));
		tw1 = 48'({$urandom, $urandom}) | 48'h010101010101;
		tw2 = ~tw1;
		repeat (8) @(posedge mclk);
		#1 rst_n = 1;
		u_host.init();
		`CHK(mode_out, 3'h0)
		ph = 14'($urandom);
		u_host.wr(8'h14, {2'h0, ph[13:8]});
		u_host.wr(8'h15, ph[7:0]);
		u_host.wr(8'h30, 8'hFF);
		for (int i = 0; i < 6; i++) begin
			exp_q.push_back({1'b0, tw1 & ~(48'hFFFFFFFFFFFF >> (8 * (i + 1)))});
			u_host.wr(8'h04 + 8'(i), tw1[47 - 8 * i -: 8]);
			u_host.wr(8'h0A + 8'(i), tw2[47 - 8 * i -: 8]);
		end
		`CHK(14'(cosine_phase - sine_phase), ph)
		for (int m = 0; m < 8; m++) begin
			u_host.wr(8'h1F, 8'(m));
			`CHK(mode_out, 3'(m))
			if (m inside {1, 2}) exp_q.push_back({1'b1, tw2});
			if (m inside {1, 2}) exp_q.push_back({1'b0, tw1});
			u_host.key(1);
			u_host.key(0);
		end
		exp_q.push_back(49'h0);
		u_host.init();
		repeat (4) @(posedge mclk);
		`CHK(exp_q.size() == 0, 1'b1)
		results();
	end
endmodule : tb_top
bind dms_mode_tone dms_mode_tone_checker #(.ACC_W(ACC_W), .OUT_W(OUT_W)) u_chk(.*);
